// ---- hw/ccpu_pkg.sv ----
/*
 * Package of the capture, compare and pulse-width unit: register indices,
 * field positions, mode codes, reset values and the bundles its ports carry.
 * Assumes a 32-bit AXI4-Lite register bus and externally kept timers.
 */
package ccpu_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    // Register indices; the byte address is four times the index.
    localparam logic [5:0] IDX_VALUE_LOW = 6'h15;
    localparam logic [5:0] IDX_VALUE_HIGH = 6'h16;
    localparam logic [5:0] IDX_CONTROL = 6'h17;
    localparam logic [5:0] IDX_FLAG = 6'h0c;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] CONTROL_WMASK = 8'h3f;
    localparam int unsigned FLAG_BIT = 2;
    localparam int unsigned DUTY_LSB_LO = 4;
    localparam int unsigned DUTY_LSB_HI = 5;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // Mode codes and prescaler limits
    // ------------------------------------------------------------------
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_4 = 4'h6;
    localparam logic [3:0] MODE_CAP_16 = 4'h7;
    localparam logic [3:0] MODE_CMP_SET = 4'h8;
    localparam logic [3:0] MODE_CMP_CLR = 4'h9;
    localparam logic [3:0] MODE_CMP_SOFT = 4'ha;
    localparam logic [3:0] MODE_CMP_TRIG = 4'hb;
    localparam logic [3:0] PRE_LAST_4 = 4'h3;
    localparam logic [3:0] PRE_LAST_16 = 4'hf;

    typedef enum logic [1:0] {
        KIND_OFF,
        KIND_CAPTURE,
        KIND_COMPARE,
        KIND_PWM
    } ccpu_kind_e;

    // ------------------------------------------------------------------
    // Port bundles
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [ADDR_W-1:0] araddr;
        logic arvalid;
        logic rready;
    } ccpu_axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ccpu_axi_rsp_s;

    typedef struct packed {
        logic [15:0] t1_count;
        logic [7:0] t2_count;
        logic t2_inc;
        logic [1:0] t2_frac;
        logic [7:0] period;
    } ccpu_timer_s;

endpackage

// ---- hw/ccpu_top.sv ----
/*
 * Capture, compare and pulse-width unit with an AXI4-Lite register slave.
 * Assumes timers kept outside, a port B latch and direction bit outside,
 * and a pad whose level is resolved from unit_pin_o and unit_pin_oe_o.
 */
// Notes on behaviour
// - Mode 0000 turns the unit off and resets prescaler and output latch.
// - Modes 0100-0111 capture on fall, rise, 4th rise, 16th rise.
// - Modes 1000/1001 drive pin high/low on match and set flag.
// - Mode 1010 only sets the flag on match; pin unchanged.
// - Mode 1011 sets flag and pulses trigger resetting first timer.
// - Modes 11xx select pulse-width output of up to 10 bits.
// - A capture copies the 16-bit first timer into both value bytes.
// - Each capture sets flag bit 2; only software clears it.
// - A new capture overwrites an unread older value.
// - Prescaler counter clears whenever off or not capturing.
// - Switching between capture prescalers keeps the counter running.
// - Pin driven as output in capture mode can cause captures.
// - Compare runs continuously; pin action and flag happen together.
// - Writing zero to control forces the unit output latch low.
// - Control bits 5-4 are duty low bits; low byte holds upper eight.
// - Low, high and control bytes are readable and writable; high byte writes are ignored in pulse-width modes.
// - Capture and compare use first timer; pulse-width uses second.
// - Control bits 7-6 read as zero.
// - At period end latch duty, set pin unless duty zero.
// - Pin clears when duty equals second timer with two low bits.
`timescale 1ns/10ps
`default_nettype none

module ccpu_top (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // Register bus
    input wire ccpu_pkg::ccpu_axi_req_s axi_req_i,
    output ccpu_pkg::ccpu_axi_rsp_s axi_rsp_o,
    // Timer view
    input wire ccpu_pkg::ccpu_timer_s timer_i,
    output logic special_event_o,
    // Port and pin
    input wire logic port_dir_input_i,
    input wire logic port_data_latch_i,
    input wire logic unit_pin_i,
    output logic unit_pin_o,
    output logic unit_pin_oe_o,
    // Flag
    output logic unit_irq_flag_o
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [7:0] value_low_ff, value_high_ff, control_ff;
    logic [31:0] w_data_ff, rdata_ff;
    logic [3:0] prescale_cnt_ff, w_strb_ff;
    logic [1:0] duty_lat_ff, bresp_ff, rresp_ff;
    logic [ccpu_pkg::ADDR_W-1:0] aw_addr_ff;
    logic flag_ff, unit_latch_ff, match_ff, trig_ff;
    logic sync1_ff, sync2_ff, prev_ff;
    logic aw_held_ff, w_held_ff, bvalid_ff, rvalid_ff;

    logic [3:0] mode, pre_last;
    ccpu_pkg::ccpu_kind_e kind;
    logic [5:0] wr_idx;
    logic [7:0] wr_byte;
    logic [31:0] nxt_rdata;
    logic [9:0] duty_next;
    logic wr_go, wr_low, wr_high, wr_ctrl, wr_flag, wr_hit, rd_take;
    logic nxt_rhit, rise, fall, cap_event, cap_src;
    logic match, match_start, period_end, duty_clear;

    assign mode = control_ff[3:0];

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    // Mode decode table.
    always_comb begin
        case (mode[3:2])
            2'h1: kind = ccpu_pkg::KIND_CAPTURE;
            2'h2: kind = ccpu_pkg::KIND_COMPARE;
            2'h3: kind = ccpu_pkg::KIND_PWM;
            default: kind = ccpu_pkg::KIND_OFF;
        endcase
    end

    // ------------------------------------------------------------------
    // Bus write path
    // ------------------------------------------------------------------
    assign axi_rsp_o.awready = !aw_held_ff && !bvalid_ff;
    assign axi_rsp_o.wready = !w_held_ff && !bvalid_ff;
    assign axi_rsp_o.bvalid = bvalid_ff;
    assign axi_rsp_o.bresp = bresp_ff;
    assign wr_go = aw_held_ff && w_held_ff && !bvalid_ff;
    assign wr_idx = aw_addr_ff[7:2];
    assign wr_byte = w_data_ff[7:0];
    assign wr_hit = (wr_idx == ccpu_pkg::IDX_VALUE_LOW)
        || (wr_idx == ccpu_pkg::IDX_VALUE_HIGH)
        || (wr_idx == ccpu_pkg::IDX_CONTROL)
        || (wr_idx == ccpu_pkg::IDX_FLAG);
    assign wr_low = wr_go && w_strb_ff[0]
        && (wr_idx == ccpu_pkg::IDX_VALUE_LOW);
    assign wr_high = wr_go && w_strb_ff[0]
        && (wr_idx == ccpu_pkg::IDX_VALUE_HIGH);
    assign wr_ctrl = wr_go && w_strb_ff[0]
        && (wr_idx == ccpu_pkg::IDX_CONTROL);
    assign wr_flag = wr_go && w_strb_ff[0]
        && (wr_idx == ccpu_pkg::IDX_FLAG);

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= '0;
        end else if (axi_req_i.awvalid && axi_rsp_o.awready) begin
            aw_held_ff <= 1'b1;
            aw_addr_ff <= axi_req_i.awaddr;
        end else if (wr_go) begin
            aw_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            w_held_ff <= 1'b0;
            w_data_ff <= '0;
            w_strb_ff <= '0;
        end else if (axi_req_i.wvalid && axi_rsp_o.wready) begin
            w_held_ff <= 1'b1;
            w_data_ff <= axi_req_i.wdata;
            w_strb_ff <= axi_req_i.wstrb;
        end else if (wr_go) begin
            w_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= ccpu_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_hit ? ccpu_pkg::RESP_OKAY
                               : ccpu_pkg::RESP_SLVERR;
        end else if (axi_req_i.bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Bus read path
    // ------------------------------------------------------------------
    assign axi_rsp_o.arready = !rvalid_ff;
    assign axi_rsp_o.rvalid = rvalid_ff;
    assign axi_rsp_o.rdata = rdata_ff;
    assign axi_rsp_o.rresp = rresp_ff;
    assign rd_take = axi_req_i.arvalid && !rvalid_ff;

    always_comb begin
        nxt_rdata = '0;
        nxt_rhit = 1'b1;
        case (axi_req_i.araddr[7:2])
            ccpu_pkg::IDX_VALUE_LOW: nxt_rdata[7:0] = value_low_ff;
            ccpu_pkg::IDX_VALUE_HIGH: nxt_rdata[7:0] = value_high_ff;
            ccpu_pkg::IDX_CONTROL: nxt_rdata[7:0] = control_ff;
            ccpu_pkg::IDX_FLAG: nxt_rdata[ccpu_pkg::FLAG_BIT] = flag_ff;
            default: nxt_rhit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= ccpu_pkg::RESP_OKAY;
        end else if (rd_take) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rhit ? ccpu_pkg::RESP_OKAY
                                 : ccpu_pkg::RESP_SLVERR;
        end else if (axi_req_i.rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            control_ff <= ccpu_pkg::CONTROL_RESET;
        end else if (wr_ctrl) begin
            control_ff <= wr_byte & ccpu_pkg::CONTROL_WMASK;
        end
    end

    // ------------------------------------------------------------------
    // Pin and capture edge detection
    // ------------------------------------------------------------------
    assign unit_pin_oe_o = !port_dir_input_i;
    assign unit_pin_o = (kind == ccpu_pkg::KIND_COMPARE
        || kind == ccpu_pkg::KIND_PWM) ? unit_latch_ff : port_data_latch_i;
    assign cap_src = unit_pin_oe_o ? unit_pin_o : unit_pin_i;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            sync1_ff <= cap_src;
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
        end
    end

    assign rise = sync2_ff && !prev_ff;
    assign fall = !sync2_ff && prev_ff;

    always_comb begin
        case (mode)
            ccpu_pkg::MODE_CAP_4: pre_last = ccpu_pkg::PRE_LAST_4;
            ccpu_pkg::MODE_CAP_16: pre_last = ccpu_pkg::PRE_LAST_16;
            default: pre_last = 4'h0;
        endcase
    end

    // Counter may exceed a smaller limit.
    assign cap_event = (kind == ccpu_pkg::KIND_CAPTURE)
        && ((mode == ccpu_pkg::MODE_CAP_FALL) ? fall
            : (rise && prescale_cnt_ff >= pre_last));

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            prescale_cnt_ff <= 4'h0;
        end else if (kind != ccpu_pkg::KIND_CAPTURE) begin
            prescale_cnt_ff <= 4'h0;
        end else if (mode != ccpu_pkg::MODE_CAP_FALL && rise) begin
            prescale_cnt_ff <= cap_event ? 4'h0 : prescale_cnt_ff + 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // Compare and pulse-width events
    // ------------------------------------------------------------------
    // Continuous compare on first timer.
    assign match = (kind == ccpu_pkg::KIND_COMPARE)
        && (timer_i.t1_count == {value_high_ff, value_low_ff});
    assign match_start = match && !match_ff;
    assign period_end = (kind == ccpu_pkg::KIND_PWM) && timer_i.t2_inc
        && (timer_i.t2_count == timer_i.period);
    // Duty from low byte and control bits 5-4.
    assign duty_next = {value_low_ff,
        control_ff[ccpu_pkg::DUTY_LSB_HI:ccpu_pkg::DUTY_LSB_LO]};
    // Duty compare with two low bits.
    assign duty_clear = (kind == ccpu_pkg::KIND_PWM)
        && ({value_high_ff, duty_lat_ff}
            == {timer_i.t2_count, timer_i.t2_frac});

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            match_ff <= 1'b0;
            trig_ff <= 1'b0;
        end else begin
            match_ff <= match;
            trig_ff <= match_start && (mode == ccpu_pkg::MODE_CMP_TRIG);
        end
    end

    assign special_event_o = trig_ff;

    // ------------------------------------------------------------------
    // Unit output latch
    // ------------------------------------------------------------------
    // Off clears latch.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            unit_latch_ff <= 1'b0;
            duty_lat_ff <= 2'h0;
        end else if (kind == ccpu_pkg::KIND_OFF
                     || (wr_ctrl && wr_byte == 8'h00)) begin
            unit_latch_ff <= 1'b0;
            duty_lat_ff <= 2'h0;
        end else if (period_end) begin
            unit_latch_ff <= (duty_next != 10'h000);
            duty_lat_ff <= duty_next[1:0];
        end else if (duty_clear) begin
            unit_latch_ff <= 1'b0;
        end else if (match_start && mode == ccpu_pkg::MODE_CMP_SET) begin
            unit_latch_ff <= 1'b1;
        end else if (match_start && mode == ccpu_pkg::MODE_CMP_CLR) begin
            unit_latch_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Value registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            value_low_ff <= 8'h00;
        end else if (cap_event) begin
            value_low_ff <= timer_i.t1_count[7:0];
        end else if (wr_low) begin
            value_low_ff <= wr_byte;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            value_high_ff <= 8'h00;
        end else if (cap_event) begin
            value_high_ff <= timer_i.t1_count[15:8];
        end else if (period_end) begin
            value_high_ff <= value_low_ff;
        end else if (wr_high && kind != ccpu_pkg::KIND_PWM) begin
            value_high_ff <= wr_byte;
        end
    end

    // ------------------------------------------------------------------
    // Flag
    // ------------------------------------------------------------------
    // Capture and compare match flags.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            flag_ff <= 1'b0;
        end else if (cap_event || match_start) begin
            flag_ff <= 1'b1;
        end else if (wr_flag && !wr_byte[ccpu_pkg::FLAG_BIT]) begin
            flag_ff <= 1'b0;
        end
    end

    assign unit_irq_flag_o = flag_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    ctrl_upper_zero_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        control_ff[7:6] == 2'h0)
        else $error("Control upper bits not zero.");

    off_clears_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (mode == ccpu_pkg::MODE_OFF && !wr_ctrl) |=>
            (prescale_cnt_ff == 4'h0 && !unit_latch_ff))
        else $error("Off mode left state uncleared.");

    capture_copy_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        cap_event |=>
            {value_high_ff, value_low_ff} == $past(timer_i.t1_count))
        else $error("Capture did not copy the timer.");

    capture_flag_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (cap_event || match_start) |=> flag_ff)
        else $error("Flag not set by event.");

    flag_hold_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (flag_ff && !wr_flag) |=> flag_ff)
        else $error("Flag cleared without software.");

    compare_set_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (match_start && mode == ccpu_pkg::MODE_CMP_SET && !wr_ctrl)
            |=> unit_latch_ff)
        else $error("Compare set did not drive high.");

    soft_keep_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (mode == ccpu_pkg::MODE_CMP_SOFT && !wr_ctrl)
            |=> $stable(unit_latch_ff))
        else $error("Software compare moved the pin.");

    trigger_pulse_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (match_start && mode == ccpu_pkg::MODE_CMP_TRIG)
            |=> special_event_o ##1 !special_event_o)
        else $error("Trigger pulse missing or long.");

    prescale_16_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (cap_event && mode == ccpu_pkg::MODE_CAP_16)
            |-> prescale_cnt_ff == ccpu_pkg::PRE_LAST_16)
        else $error("Sixteenth-edge capture taken early.");

    pwm_latch_a: assert property (
        @(posedge clk_i) disable iff (!rst_b_i)
        (period_end && !wr_ctrl) |=> (value_high_ff == $past(value_low_ff)
            && unit_latch_ff == ($past(duty_next) != 10'h000)))
        else $error("Period end did not latch duty.");

endmodule

`default_nettype wire

// ---- dv/ccpu_pin_model.sv ----
/*
 * Far-side model of the unit pin: an external signal source or load.
 * Assumes the unit drives the pad only while its output enable is high.
 */
`timescale 1ns/10ps
`default_nettype none

module ccpu_pin_model (
    // Unit side
    input wire logic drive_i,
    input wire logic oe_i,
    // Level the source offers
    input wire logic level_i,
    // Resolved pad
    output logic pad_o
);
    assign pad_o = oe_i ? drive_i : level_i;
endmodule

`default_nettype wire

// ---- dv/tb.sv ----
/*
 * Self-checking testbench of the capture, compare and pulse-width unit.
 * Assumes the AXI4-Lite slave, pin and timer view of ccpu_top.
 */
`timescale 1ns/10ps
`default_nettype none

module tb;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    ccpu_pkg::ccpu_axi_req_s req = '0;
    ccpu_pkg::ccpu_axi_rsp_s rsp;
    ccpu_pkg::ccpu_timer_s tmr = '0;
    logic dir_in = 1'b1;
    logic port_latch = 1'b1;
    logic ext_level = 1'b0;
    logic pad, pin_o, pin_oe, sev, flag, seen;
    logic [33:0] exp_q[$];
    logic [1:0] bq[$];
    logic [15:0] v;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;
    int seed = 84;
    int n;

    always #2.5 clk_i = ~clk_i;

    ccpu_top i_ccpu_top (.clk_i(clk_i), .rst_b_i(rst_b_i), .axi_req_i(req),
        .axi_rsp_o(rsp), .timer_i(tmr), .special_event_o(sev),
        .port_dir_input_i(dir_in), .port_data_latch_i(port_latch),
        .unit_pin_i(pad), .unit_pin_o(pin_o), .unit_pin_oe_o(pin_oe),
        .unit_irq_flag_o(flag));
    ccpu_pin_model i_ccpu_pin_model (.drive_i(pin_o), .oe_i(pin_oe),
        .level_i(ext_level), .pad_o(pad));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("errors=%0d check_count=%0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        bq.push_back((idx == ccpu_pkg::IDX_VALUE_LOW)
            || (idx == ccpu_pkg::IDX_VALUE_HIGH)
            || (idx == ccpu_pkg::IDX_CONTROL)
            || (idx == ccpu_pkg::IDX_FLAG)
            ? ccpu_pkg::RESP_OKAY : ccpu_pkg::RESP_SLVERR);
        req.awaddr <= {idx, 2'b00};
        req.wdata <= {24'h0, d};
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        do begin
            @(posedge clk_i);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
        end while (!rsp.bvalid);
    endtask

    task automatic rd(input logic [5:0] idx, input logic [33:0] e);
        exp_q.push_back(e);
        req.araddr <= {idx, 2'b00};
        req.arvalid <= 1'b1;
        do begin
            @(posedge clk_i);
            if (rsp.arready) req.arvalid <= 1'b0;
        end while (!rsp.rvalid);
    endtask

    function automatic logic [33:0] ok(input logic [7:0] d);
        return {ccpu_pkg::RESP_OKAY, 24'h0, d};
    endfunction

    task automatic mode(input logic [3:0] m);
        wr(ccpu_pkg::IDX_CONTROL, {4'h0, m});
    endtask

    task automatic edges(input logic lvl, input int cnt);
        repeat (cnt) begin
            ext_level <= ~lvl;
            repeat (4) @(posedge clk_i);
            ext_level <= lvl;
            repeat (4) @(posedge clk_i);
        end
    endtask

    task automatic match();
        tmr.t1_count <= v;
        repeat (3) @(posedge clk_i);
    endtask

    // ------------------------------------------------------------------
    // Read and write response monitor and timeout
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rsp.rvalid && req.rready) begin
            chk({rsp.rresp, rsp.rdata}, exp_q.pop_front());
        end
        if (rsp.bvalid && req.bready) begin
            chk({32'h0, rsp.bresp}, {32'h0, bq.pop_front()});
        end
        cycles++;
        if (cycles == 20000) begin
            errors++;
            conclude();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        req.bready <= 1'b1;
        req.rready <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_b_i <= 1'b1;
        @(posedge clk_i);
        rd(ccpu_pkg::IDX_CONTROL, ok(8'h00));
        wr(ccpu_pkg::IDX_CONTROL, 8'hff);
        rd(ccpu_pkg::IDX_CONTROL, ok(8'h3f));
        wr(ccpu_pkg::IDX_CONTROL, 8'h00);
        rd(6'h01, {ccpu_pkg::RESP_SLVERR, 32'h0});
        wr(6'h01, 8'h55);
        v = 16'($random(seed));
        tmr.t1_count <= v;
        mode(ccpu_pkg::MODE_CAP_RISE);
        edges(1'b1, 1);
        rd(ccpu_pkg::IDX_VALUE_LOW, ok(v[7:0]));
        rd(ccpu_pkg::IDX_VALUE_HIGH, ok(v[15:8]));
        rd(ccpu_pkg::IDX_FLAG, ok(8'h04));
        v = 16'($random(seed));
        tmr.t1_count <= v;
        mode(ccpu_pkg::MODE_CAP_FALL);
        edges(1'b0, 1);
        rd(ccpu_pkg::IDX_VALUE_LOW, ok(v[7:0]));
        rd(ccpu_pkg::IDX_VALUE_HIGH, ok(v[15:8]));
        for (int i = 0; i < 2; i++) begin
            n = (i == 0) ? 4 : 16;
            wr(ccpu_pkg::IDX_CONTROL, 8'h00);
            mode(i == 0 ? ccpu_pkg::MODE_CAP_4 : ccpu_pkg::MODE_CAP_16);
            wr(ccpu_pkg::IDX_FLAG, 8'h00);
            edges(1'b1, n - 1);
            chk({33'h0, flag}, 34'h0);
            edges(1'b1, 1);
            chk({33'h0, flag}, 34'h1);
        end
        v = 16'($random(seed));
        tmr.t1_count <= v;
        dir_in <= 1'b0;
        mode(ccpu_pkg::MODE_CAP_RISE);
        wr(ccpu_pkg::IDX_FLAG, 8'h00);
        port_latch <= 1'b0;
        repeat (4) @(posedge clk_i);
        port_latch <= 1'b1;
        repeat (4) @(posedge clk_i);
        chk({33'h0, pin_oe}, 34'h1);
        rd(ccpu_pkg::IDX_VALUE_LOW, ok(v[7:0]));
        rd(ccpu_pkg::IDX_FLAG, ok(8'h04));
        dir_in <= 1'b0;
        v = 16'($random(seed));
        tmr.t1_count <= v + 16'h1;
        wr(ccpu_pkg::IDX_VALUE_LOW, v[7:0]);
        wr(ccpu_pkg::IDX_VALUE_HIGH, v[15:8]);
        mode(ccpu_pkg::MODE_CMP_SET);
        wr(ccpu_pkg::IDX_FLAG, 8'h00);
        match();
        chk({32'h0, pin_o, flag}, 34'h3);
        tmr.t1_count <= v + 16'h1;
        mode(ccpu_pkg::MODE_CMP_CLR);
        match();
        chk({33'h0, pin_o}, 34'h0);
        tmr.t1_count <= v + 16'h1;
        mode(ccpu_pkg::MODE_CMP_SET);
        match();
        tmr.t1_count <= v + 16'h1;
        wr(ccpu_pkg::IDX_CONTROL, 8'h00);
        mode(ccpu_pkg::MODE_CMP_SOFT);
        wr(ccpu_pkg::IDX_FLAG, 8'h00);
        match();
        chk({32'h0, pin_o, flag}, 34'h1);
        tmr.t1_count <= v + 16'h1;
        mode(ccpu_pkg::MODE_CMP_TRIG);
        tmr.t1_count <= v;
        seen = 1'b0;
        repeat (3) @(posedge clk_i) seen = seen | sev;
        chk({33'h0, seen}, 34'h1);
        wr(ccpu_pkg::IDX_VALUE_LOW, 8'h02);
        mode(4'hc);
        tmr.period <= 8'h04;
        tmr.t2_count <= 8'h04;
        tmr.t2_inc <= 1'b1;
        @(posedge clk_i);
        tmr.t2_inc <= 1'b0;
        tmr.t2_count <= 8'h00;
        repeat (2) @(posedge clk_i);
        chk({33'h0, pin_o}, 34'h1);
        rd(ccpu_pkg::IDX_VALUE_HIGH, ok(8'h02));
        tmr.t2_count <= 8'h02;
        repeat (2) @(posedge clk_i);
        chk({33'h0, pin_o}, 34'h0);
        repeat (2) @(posedge clk_i);
        conclude();
    end
endmodule

`default_nettype wire
